// *** core/dshp_fifo.sv ***
// shared constants of the display serial host port, and its receive fifo.
// assumes a single clock mclk and a synchronous active-low reset.

// ****************************************
// constants
// ****************************************
package dshp_pkg;
  localparam logic MODE_4WIRE = 1'b0;
  localparam logic MODE_3WIRE = 1'b1;
  localparam logic [3:0] LAST_BIT_4WIRE = 4'h7;
  localparam logic [3:0] LAST_BIT_3WIRE = 4'h8;
  localparam logic [3:0] FLAG_BIT_POS = 4'h0;
  localparam logic [3:0] FIRST_PAYLOAD_POS = 4'h1;
  localparam logic [3:0] OUT_BITS_AFTER_MSB = 4'h7;
  localparam logic [7:0] NO_READ_BYTE = 8'h00;
  // the strap follows its pin until both synchroniser stages hold it
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic FLAG_COMMAND = 1'b0;
  localparam logic FLAG_DATA = 1'b1;
  localparam int RX_WIDTH = 9;
  localparam int RX_DEPTH = 4;
  localparam int MCLK_KHZ = 20000;
  localparam int SCL_WRITE_MAX_KHZ = 20000;
  localparam int SCL_READ_MAX_KHZ = 2500;
  // four mclk samples per scl period are needed to see both edges reliably
  localparam int SAMPLES_PER_SCL = 4;
  localparam int SCL_USABLE_MAX_KHZ = MCLK_KHZ / SAMPLES_PER_SCL;
endpackage : dshp_pkg

// ****************************************
// fifo
// ****************************************
module dshp_fifo #(
  parameter int WIDTH = dshp_pkg::RX_WIDTH,
  parameter int DEPTH = dshp_pkg::RX_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("dshp_fifo: depth must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic [WIDTH-1:0] dout_q, dout_d;
  logic push, pop, empty, full;

  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = dout_q;
  assign push = in_valid & ~full;
  assign pop = out_ready & ~empty;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      wr_d = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
    // head word is kept in a register; bypass when writing into an empty fifo
    if (rd_d == wr_q && push) begin
      dout_d = in_data;
    end else begin
      dout_d = mem_q[rd_d[AW-1:0]];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      dout_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      dout_q <= dout_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule // dshp_fifo

// *** core/dshp_fifo_end.sv ***
// holds no logic; the fifo and the shared constants live in dshp_fifo.sv.
// assumes nothing of its surroundings.

// *** core/dshp_port.sv ***
// serial host port of a display controller: 4-wire and 3-wire (9-bit) modes.
// assumes all pin inputs are asynchronous to mclk and scl is at most mclk/4.

// ****************************************
// port
// ****************************************
// Behaviour
// [RQ1] strap picks 4-wire or 3-wire 9-bit mode
// [RQ2] 4-wire: dc low command, high data
// [RQ3] host starts 4-wire read with command byte
// [RQ4] host raises dc; later bytes are read
// [RQ5] read byte shifted out on falling edges
// [RQ6] read data msb first, bit 7 to 0
// [RQ7] host ties dc low in 3-wire mode
// [RQ8] 3-wire: nine bits captured on rising edges
// [RQ9] frame is flag bit then d7..d0
// [RQ10] flag 0 command, flag 1 data
// [RQ11] host reads in 9-bit frames, flags 0/1
// [RQ12] 3-wire read: data out after flag bit
// [RQ13] host write clock at most 20 MHz; mclk sampling here follows scl only up to mclk/4, 5 MHz
// [RQ14] host read clock at most 2.5 MHz
// [RQ15] chip select high clears partial frame
module dshp_port (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic iface_strap,
  input wire logic cs_n,
  input wire logic scl,
  input wire logic sdi,
  input wire logic dc,
  output logic sdo,
  output logic sdo_oe_n,
  output logic mode_3wire,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_byte,
  output logic rx_is_data,
  output logic overrun,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte,
  output logic rd_taken
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  // order: strap, cs_n, scl, sdi, dc
  logic [4:0] s1_q, s2_q;
  logic scl_prev_q;
  logic strap_s, cs_s, scl_s, sdi_s, dc_s;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_q <= 5'h08;
      s2_q <= 5'h08;
      scl_prev_q <= 1'b0;
    end else begin
      s1_q <= {iface_strap, cs_n, scl, sdi, dc};
      s2_q <= s1_q;
      scl_prev_q <= s2_q[2];
    end
  end

  assign strap_s = s2_q[4];
  assign cs_s = s2_q[3];
  assign scl_s = s2_q[2];
  assign sdi_s = s2_q[1];
  assign dc_s = s2_q[0];

  logic rise, fall, selected;
  assign rise = scl_s & ~scl_prev_q;
  assign fall = ~scl_s & scl_prev_q;
  assign selected = ~cs_s;

  // ****************************************
  // mode strap
  // ****************************************
  // synchronisers restart from their reset value, so the strap is followed
  // for three edges after release and only then frozen
  logic mode_q, mode_d;
  logic [1:0] settle_q, settle_d;

  always_comb begin
    mode_d = mode_q;
    settle_d = settle_q;
    if (settle_q != dshp_pkg::STRAP_SETTLE) begin
      mode_d = strap_s; // [RQ1]
      settle_d = settle_q + 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_q <= dshp_pkg::MODE_4WIRE;
      settle_q <= 2'h0;
    end else begin
      mode_q <= mode_d;
      settle_q <= settle_d;
    end
  end

  assign mode_3wire = mode_q;

  // ****************************************
  // receive shifter
  // ****************************************
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic flag_q, flag_d;
  logic skip_q, skip_d;
  logic last_bit, push;
  logic [8:0] frame;
  logic fifo_in_ready;
  logic start_out;

  always_comb begin
    if (mode_q == dshp_pkg::MODE_3WIRE) begin
      last_bit = (cnt_q == dshp_pkg::LAST_BIT_3WIRE); // [RQ8]
      frame = {flag_q, sh_q[6:0], sdi_s}; // [RQ9] [RQ10]
    end else begin
      last_bit = (cnt_q == dshp_pkg::LAST_BIT_4WIRE);
      // dc is ignored entirely in 3-wire mode, only 4-wire reads it here
      frame = {dc_s, sh_q[6:0], sdi_s}; // [RQ2] [RQ7]
    end
  end

  // bytes clocked while the device answers a read are dummies, not pushed
  assign push = selected & rise & last_bit & ~skip_q;

  always_comb begin
    cnt_d = cnt_q;
    sh_d = sh_q;
    flag_d = flag_q;
    skip_d = skip_q;
    if (!selected) begin
      cnt_d = 4'h0; // [RQ15]
      skip_d = 1'b0; // [RQ15]
      flag_d = dshp_pkg::FLAG_COMMAND;
    end else begin
      if (start_out) begin
        skip_d = 1'b1;
      end
      if (rise) begin
        if (last_bit) begin
          cnt_d = 4'h0;
          skip_d = 1'b0;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
        if (mode_q == dshp_pkg::MODE_3WIRE && cnt_q == dshp_pkg::FLAG_BIT_POS) begin
          flag_d = sdi_s; // [RQ9]
        end else begin
          sh_d = {sh_q[6:0], sdi_s};
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      flag_q <= dshp_pkg::FLAG_COMMAND;
      skip_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      flag_q <= flag_d;
      skip_q <= skip_d;
    end
  end

  // ****************************************
  // transmit shifter
  // ****************************************
  // a read byte starts on the falling edge that opens a data byte: in 4-wire
  // the edge after a byte's last rise with dc high, in 3-wire the edge after
  // a flag bit of 1. without offered data the device sends a filler byte.
  logic [7:0] out_q, out_d;
  logic [3:0] left_q, left_d;
  logic drv_q, drv_d;
  logic sdo_q, sdo_d;
  logic [7:0] load_byte;

  always_comb begin
    if (mode_q == dshp_pkg::MODE_3WIRE) begin
      start_out = selected & fall & (cnt_q == dshp_pkg::FIRST_PAYLOAD_POS)
                  & (flag_q == dshp_pkg::FLAG_DATA); // [RQ11] [RQ12]
    end else begin
      start_out = selected & fall & (cnt_q == 4'h0) & (dc_s == dshp_pkg::FLAG_DATA)
                  & (left_q == 4'h0); // [RQ3] [RQ4]
    end
  end

  assign load_byte = rd_valid ? rd_byte : dshp_pkg::NO_READ_BYTE;
  assign rd_taken = start_out & rd_valid;

  always_comb begin
    out_d = out_q;
    left_d = left_q;
    drv_d = drv_q;
    sdo_d = sdo_q;
    if (!selected) begin
      left_d = 4'h0; // [RQ15]
      drv_d = 1'b0;
      sdo_d = 1'b0;
    end else if (start_out) begin
      out_d = load_byte;
      sdo_d = load_byte[7]; // [RQ6]
      left_d = dshp_pkg::OUT_BITS_AFTER_MSB;
      drv_d = 1'b1;
    end else if (fall && left_q != 4'h0) begin
      sdo_d = out_q[6]; // [RQ5] [RQ6]
      out_d = {out_q[6:0], 1'b0};
      left_d = left_q - 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      out_q <= 8'h00;
      left_q <= 4'h0;
      drv_q <= 1'b0;
      sdo_q <= 1'b0;
    end else begin
      out_q <= out_d;
      left_q <= left_d;
      drv_q <= drv_d;
      sdo_q <= sdo_d;
    end
  end

  assign sdo = sdo_q;
  // held driven until chip select rises; bit 0 stays on the pin meanwhile
  assign sdo_oe_n = ~drv_q;

  // ****************************************
  // receive fifo
  // ****************************************
  // the host cannot be stalled, so a byte arriving into a full fifo is lost
  logic [8:0] rx_word;

  assign overrun = push & ~fifo_in_ready;

  dshp_fifo #(
    .WIDTH(dshp_pkg::RX_WIDTH),
    .DEPTH(dshp_pkg::RX_DEPTH)
  ) u_rx_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(frame),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_word)
  );

  assign rx_is_data = rx_word[8];
  assign rx_byte = rx_word[7:0];

  // write clock limit is above what mclk sampling can follow; see usable max
  initial begin
    if (dshp_pkg::SCL_USABLE_MAX_KHZ < dshp_pkg::SCL_READ_MAX_KHZ) begin
      $error("dshp_port: mclk too slow for the read clock rate"); // [RQ14]
    end
    if (dshp_pkg::SCL_WRITE_MAX_KHZ <= 0) begin
      $error("dshp_port: write clock limit must be positive"); // [RQ13]
    end
  end
endmodule // dshp_port

// *** sim/dshp_host_model.sv ***
// host master on the serial pins of the display port.
// assumes its tasks are called 1 ns after an mclk edge.
module dshp_host_model (
  output logic cs_n,
  output logic scl,
  output logic sdi,
  output logic dc,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  // 400 ns clock period, under the write limit and at the read limit
  initial begin
    cs_n = 1'b1;
    scl = 1'b0;
    sdi = 1'b0;
    dc = 1'b0;
  end
  task automatic sel(input logic on);
    #200 cs_n = !on;
    // released data line must not keep its last bit
    if (!on) sdi = !sdi;
    #200;
  endtask
  task automatic xfer(input int n, input logic [8:0] bits, input logic dv, input logic late,
    output logic [8:0] got);
    got = 9'h000;
    #200 dc = dv;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = bits[i];
      #200 scl = 1'b1;
      got = {got[7:0], sdo};
      #100 dc = (i == 0) ? late : dc;
      #100 scl = 1'b0;
    end
  endtask
endmodule // dshp_host_model

// *** sim/dshp_port_props.sv ***
// concurrent checks of dshp_port, seeing only its pins.
// assumes the strap changes only while reset is held.
module dshp_port_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic iface_strap,
  input wire logic cs_n,
  input wire logic scl,
  input wire logic dc,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire logic mode_3wire,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] rx_byte,
  input wire logic rx_is_data,
  input wire logic overrun,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte,
  input wire logic rd_taken
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ********
  // properties
  // ********
  property p_mode; $past(rst_n, 4) |-> mode_3wire == iface_strap; endproperty
  a_mode: assert property (p_mode) else $error("mode off strap");
  property p_idle; cs_n [*5] |-> sdo_oe_n && !sdo; endproperty
  a_idle: assert property (p_idle) else $error("sdo driven while idle");
  property p_shift; !sdo_oe_n && $changed(sdo) |-> !$past(scl) && !$past(scl, 2); endproperty
  a_shift: assert property (p_shift) else $error("sdo moved off a fall");
  property p_load; rd_taken |=> !sdo_oe_n && sdo == $past(rd_byte[7]); endproperty
  a_load: assert property (p_load) else $error("first bit not msb");
  property p_ack; rd_taken |-> rd_valid ##1 !rd_taken; endproperty
  a_ack: assert property (p_ack) else $error("bad read ack");
  property p_hold; rx_valid && !rx_ready |=> rx_valid && $stable({rx_is_data, rx_byte}); endproperty
  a_hold: assert property (p_hold) else $error("rx head lost");
  property p_push; $rose(rx_valid) |-> !$past(cs_n, 3); endproperty
  a_push: assert property (p_push) else $error("push outside select");
  property p_ovr; overrun |-> rx_valid; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun on non-full");
  property p_arm; $fell(sdo_oe_n) && !mode_3wire |-> $past(dc, 3); endproperty
  a_arm: assert property (p_arm) else $error("read armed by command");
  c_read: cover property (rd_taken);
  c_ovr: cover property (overrun);
  c_3w: cover property (mode_3wire && $rose(rx_valid));
endmodule // dshp_port_props

bind dshp_port dshp_port_props dshp_port_props_i (.mclk(mclk), .rst_n(rst_n),
  .iface_strap(iface_strap), .cs_n(cs_n), .scl(scl), .dc(dc), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
  .mode_3wire(mode_3wire), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte),
  .rx_is_data(rx_is_data), .overrun(overrun), .rd_valid(rd_valid), .rd_byte(rd_byte),
  .rd_taken(rd_taken));

// *** sim/dshp_port_test.sv ***
// self-checking bench of dshp_port driven by a host model.
// assumes the checker binds itself to dshp_port.
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module dshp_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst_n, strap, stall, rx_ready, rd_valid;
  logic [7:0] rd_byte;
  logic [16:0] lf;
  logic cs_n, scl, sdi, dc, sdo, sdo_oe_n, mode_3wire, rx_valid, rx_is_data, overrun, rd_taken;
  logic [7:0] rx_byte;
  logic [8:0] q[$];
  logic [8:0] g, e;
  int fails = 0;
  int n_tests = 0;
  int ovr = 0;
  int taken_cnt = 0;
  dshp_port dshp_port_i (.mclk(mclk), .rst_n(rst_n), .iface_strap(strap), .cs_n(cs_n),
    .scl(scl), .sdi(sdi), .dc(dc), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .mode_3wire(mode_3wire),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte), .rx_is_data(rx_is_data),
    .overrun(overrun), .rd_valid(rd_valid), .rd_byte(rd_byte), .rd_taken(rd_taken));
  dshp_host_model dshp_host_model_i (.cs_n(cs_n), .scl(scl), .sdi(sdi), .dc(dc), .sdo(sdo));
  function automatic logic [16:0] nxt(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ********
  // result watcher and consumer
  // ********
  always @(posedge mclk) begin
    if (rst_n && rx_valid && rx_ready) begin
      e = q.pop_front();
      `CHK("rx", e, {rx_is_data, rx_byte})
    end
    if (overrun === 1'b1) ovr++;
    if (rd_taken === 1'b1) taken_cnt++;
  end
  always @(posedge mclk) begin
    #1;
    lf = nxt(lf);
    rx_ready = !stall && lf[0];
  end
  // ********
  // tasks
  // ********
  task automatic wr(input logic d, input logic three, input logic late);
    logic [7:0] b;
    lf = nxt(lf);
    b = lf[8:1];
    q.push_back({d, b});
    dshp_host_model_i.xfer(three ? 9 : 8, {d & three, b}, d & !three, late, g);
  endtask
  task automatic rd(input logic three, input logic offer);
    logic [7:0] b;
    int t0;
    lf = nxt(lf);
    b = lf[16:9];
    t0 = taken_cnt;
    rd_byte = b;
    rd_valid = offer;
    dshp_host_model_i.sel(1'b1);
    wr(1'b0, three, !three);
    dshp_host_model_i.xfer(three ? 9 : 8, 9'h100, !three, 1'b0, g);
    `CHK("rd", offer ? b : dshp_pkg::NO_READ_BYTE, g[7:0])
    `CHK("taken", offer, taken_cnt - t0)
    `CHK("oe_n", 1'b0, sdo_oe_n)
    rd_valid = 1'b0;
    dshp_host_model_i.sel(1'b0);
    `CHK("oe_n", 1'b1, sdo_oe_n)
  endtask
  task automatic drain;
    stall = 1'b0;
    for (int i = 0; i < 400 && q.size() > 0; i++) @(posedge mclk);
    @(posedge mclk);
    #1;
    `CHK("left", 0, q.size())
  endtask
  task automatic reset_dut;
    rst_n = 1'b0;
    repeat (5) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic wrap_up;
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    wrap_up();
  end
  // ********
  // main sequence
  // ********
  initial begin
    rst_n = 1'b0;
    strap = 1'b0;
    stall = 1'b1;
    rd_valid = 1'b0;
    rd_byte = 8'h00;
    lf = 17'h101e4;
    reset_dut();
    `CHK("mode", 1'b0, mode_3wire)
    stall = 1'b0;
    dshp_host_model_i.sel(1'b1);
    wr(1'b0, 1'b0, 1'b0);
    wr(1'b1, 1'b0, 1'b0);
    wr(1'b1, 1'b0, 1'b0);
    dshp_host_model_i.sel(1'b0);
    rd(1'b0, 1'b1);
    // a short frame must leave no trace
    dshp_host_model_i.sel(1'b1);
    dshp_host_model_i.xfer(5, 9'h0ff, 1'b0, 1'b0, g);
    dshp_host_model_i.sel(1'b0);
    dshp_host_model_i.sel(1'b1);
    wr(1'b0, 1'b0, 1'b0);
    dshp_host_model_i.sel(1'b0);
    drain();
    stall = 1'b1;
    dshp_host_model_i.sel(1'b1);
    repeat (5) wr(1'b0, 1'b0, 1'b0);
    dshp_host_model_i.sel(1'b0);
    void'(q.pop_back());
    `CHK("ovr", 1, ovr)
    drain();
    strap = 1'b1;
    reset_dut();
    dshp_host_model_i.sel(1'b1);
    wr(1'b0, 1'b1, 1'b0);
    wr(1'b0, 1'b1, 1'b0);
    dshp_host_model_i.sel(1'b0);
    rd(1'b1, 1'b1);
    rd(1'b1, 1'b0);
    drain();
    `CHK("mode", 1'b1, mode_3wire)
    wrap_up();
  end
endmodule // dshp_port_test
